// File: design/status_event_pkg.sv
// Shared constants, bit positions and command codes for the status reporting block
package status_event_pkg;

    // ----------------------------------------
    // Widths and depths
    // ----------------------------------------
    localparam int CODE_W     = 16;
    localparam int QUESTIONABLE_SUMMARY_W     = 15;
    localparam int OPERATION_SUMMARY_W     = 16;
    localparam int RSP_W      = 16;
    localparam int ERRQ_DEPTH = 16;
    localparam int OQ_DEPTH   = 16;

    // ----------------------------------------
    // Status summary byte positions
    // ----------------------------------------
    localparam int SB_ERR  = 2;
    localparam int SB_QUESTIONABLE_SUMMARY = 3;
    localparam int SB_MAV  = 4;
    localparam int SB_ESB  = 5;
    localparam int SB_RQS  = 6;
    localparam int SB_OPERATION_SUMMARY = 7;
    localparam logic [7:0] SB_RQS_EXCL = 8'hBF;

    // ----------------------------------------
    // Standard event latch positions and resets
    // ----------------------------------------
    localparam int EV_ALL_DONE   = 0;
    localparam int EV_QUERY_ERR  = 2;
    localparam int EV_DEVICE_ERR = 3;
    localparam int EV_EXEC_ERR   = 4;
    localparam int EV_PARSE_ERR  = 5;
    localparam int EV_LOCAL_BTN  = 6;
    localparam int EV_POWER_UP   = 7;
    localparam logic [7:0] STANDARD_EVENT_LATCH_LIVE = 8'hFD;
    localparam logic [7:0] STANDARD_EVENT_LATCH_RST  = 8'h80;
    localparam logic [7:0] MASK_RST  = 8'h00;

    // ----------------------------------------
    // Error codes and class bounds
    // ----------------------------------------
    localparam logic signed [CODE_W-1:0] CODE_NO_ERROR = 16'sh0000;
    localparam logic signed [CODE_W-1:0] CODE_OVERFLOW = 16'shFEA2;
    localparam logic signed [CODE_W-1:0] CODE_M100     = 16'shFF9C;
    localparam logic signed [CODE_W-1:0] CODE_M200     = 16'shFF38;
    localparam logic signed [CODE_W-1:0] CODE_M300     = 16'shFED4;
    localparam logic signed [CODE_W-1:0] CODE_M400     = 16'shFE70;
    localparam logic signed [CODE_W-1:0] CODE_M500     = 16'shFE0C;

    typedef enum logic [4:0] {
        CMD_STB_Q, CMD_ESR_Q, CMD_ESE_W, CMD_ESE_Q, CMD_SRE_W, CMD_SRE_Q,
        CMD_QEN_W, CMD_QEN_Q, CMD_QEVT_Q, CMD_QCOND_Q, CMD_OEN_W, CMD_OEN_Q,
        CMD_OEVT_Q, CMD_CLS, CMD_ERR_Q, CMD_OPC, CMD_PRESET
    } cmd_t;

    // Event latch bit that an error code sets, by hundreds class
    function automatic logic [7:0] err_class(input logic signed [CODE_W-1:0] code);
        logic [7:0] b;
        b = 8'h00;
        if (code <= CODE_M100 && code > CODE_M200) begin
            b[EV_PARSE_ERR] = 1'b1;
        end else if (code <= CODE_M200 && code > CODE_M300) begin
            b[EV_EXEC_ERR] = 1'b1;
        end else if (code <= CODE_M300 && code > CODE_M400) begin
            b[EV_DEVICE_ERR] = 1'b1;
        end else if (code <= CODE_M400 && code > CODE_M500) begin
            b[EV_QUERY_ERR] = 1'b1;
        end
        return b;
    endfunction

endpackage

// File: design/edge_event_latch.sv
// Rising-edge event latch with sticky bits and a read-clear
module edge_event_latch
    import status_event_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] cond_i,
    input  wire logic         clr_i,
    output logic      [W-1:0] latch_o
);
    logic [W-1:0] prev_q;
    logic [W-1:0] latch_q;
    logic [W-1:0] latch_d;

    // Set wins over a clear in the same cycle so no edge is lost
    always_comb begin
        latch_d = clr_i ? '0 : latch_q;
        latch_d = latch_d | (cond_i & ~prev_q);
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_q  <= '0;
            latch_q <= '0;
        end else begin
            prev_q  <= cond_i;
            latch_q <= latch_d;
        end
    end

    assign latch_o = latch_q;
endmodule

// File: design/error_queue.sv
// First-in first-out error queue with overflow marker
module error_queue
    import status_event_pkg::*;
#(
    parameter int DEPTH = ERRQ_DEPTH
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic              push_i,
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic              pop_i,
    input  wire logic              clear_i,
    output logic      [CODE_W-1:0] head_o,
    output logic                   not_empty_o,
    output logic                   stored_o,
    output logic      [CODE_W-1:0] stored_code_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);

    // Pointers wrap at the depth, which need not be a power of two
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    logic [CODE_W-1:0] mem_q [DEPTH];
    logic [PW-1:0]     wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]     cnt_q, cnt_d;
    logic              blocked_q, blocked_d;
    logic              pop_ok;

    // Last free slot takes the overflow code, then nothing more is stored
    always_comb begin
        pop_ok        = pop_i && (cnt_q != '0);
        stored_o      = push_i && !blocked_q && !clear_i;
        stored_code_o = (stored_o && cnt_q == LAST && !pop_ok) ? CODE_OVERFLOW : code_i;
        wr_d          = wr_q;
        rd_d          = rd_q;
        cnt_d         = cnt_q;
        blocked_d     = blocked_q;
        if (clear_i) begin
            wr_d      = '0;
            rd_d      = '0;
            cnt_d     = '0;
            blocked_d = 1'b0;
        end else begin
            if (pop_ok) begin
                rd_d      = bump(rd_q);
                blocked_d = 1'b0;
            end
            if (stored_o) begin
                wr_d = bump(wr_q);
                if (stored_code_o == CODE_OVERFLOW && cnt_q == LAST && !pop_ok) begin
                    blocked_d = 1'b1;
                end
            end
            cnt_d = CW'(cnt_q + CW'(stored_o) - CW'(pop_ok));
        end
    end

    always_ff @(posedge mclk_i) begin
        if (stored_o) begin
            mem_q[wr_q] <= stored_code_o;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_q      <= '0;
            rd_q      <= '0;
            cnt_q     <= '0;
            blocked_q <= 1'b0;
        end else begin
            wr_q      <= wr_d;
            rd_q      <= rd_d;
            cnt_q     <= cnt_d;
            blocked_q <= blocked_d;
        end
    end

    assign not_empty_o = (cnt_q != '0);
    assign head_o      = not_empty_o ? mem_q[rd_q] : CODE_NO_ERROR;
endmodule

// File: design/status_event_reporting.sv
// Status summary byte, standard event latch, masks and service request
//
// Summary of operation
// - Summary bits 0 and 1 read zero.
// - Summary bit 2 while errors wait queued.
// - Summary bit 3 is enabled questionable summary.
// - Summary bit 4 while output queue nonempty.
// - Summary bit 5 is enabled event summary.
// - Summary bit 6 requests service, poll reports.
// - Summary bit 7 is enabled operation summary.
// - Poll and status query return current byte.
// - Event bit 0 set when pending done.
// - Event bit 1 zero; bits 2-5 error kinds.
// - Bit 6 local button, bit 7 power-on.
// - Event query returns latch then clears it.
// - Summary is OR of status AND enable.
// - Event mask written, read, feeds bit 5.
// - Operation mask exists; operation summary stays zero.
// - Questionable mask selects bit 3 sources.
// - Service mask selects bits raising service request.
// - New message empties the output queue.
// - Error queue FIFO; empty returns no-error.
// - Overflow stores overflow code, then blocks.
// - Each queued error sets event bit by class.
// - Event bits catch rising edges, stay set.
// - Questionable event read clears; condition read not.
module status_event_reporting
    import status_event_pkg::*;
#(
    parameter int EQ_DEPTH = ERRQ_DEPTH,
    parameter int OQ_MAX   = OQ_DEPTH
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic              cmd_valid_i,
    input  wire cmd_t              cmd_code_i,
    input  wire logic [RSP_W-1:0]  cmd_data_i,
    output logic                   rsp_valid_o,
    output logic      [RSP_W-1:0]  rsp_data_o,
    input  wire logic              poll_i,
    output logic                   poll_valid_o,
    output logic      [7:0]        poll_data_o,
    input  wire logic              msg_start_i,
    input  wire logic              oq_push_i,
    input  wire logic              oq_pop_i,
    input  wire logic              ops_idle_i,
    input  wire logic              err_push_i,
    input  wire logic [CODE_W-1:0] err_code_i,
    input  wire logic [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_cond_i,
    input  wire logic              local_btn_i,
    output logic      [7:0]        status_byte_o,
    output logic                   srq_o
);
    localparam int OW = $clog2(OQ_MAX + 1);
    localparam logic [OW-1:0] OQ_FULL = OW'(OQ_MAX);

    typedef enum logic {OPC_IDLE, OPC_ARMED} opc_state_t;

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    logic cmd_esr_q, cmd_qevt_q, cmd_oevt_q, cmd_cls, cmd_err_q;

    always_comb begin
        cmd_esr_q  = cmd_valid_i && cmd_code_i == CMD_ESR_Q;
        cmd_qevt_q = cmd_valid_i && cmd_code_i == CMD_QEVT_Q;
        cmd_oevt_q = cmd_valid_i && cmd_code_i == CMD_OEVT_Q;
        cmd_cls    = cmd_valid_i && cmd_code_i == CMD_CLS;
        cmd_err_q  = cmd_valid_i && cmd_code_i == CMD_ERR_Q;
    end

    // ----------------------------------------
    // Latches and error queue
    // ----------------------------------------
    logic [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_latch;
    logic [OPERATION_SUMMARY_W-1:0] operation_summary_latch;
    logic [CODE_W-1:0] err_head, err_stored_code;
    logic              err_waiting, err_stored;

    edge_event_latch #(.W(QUESTIONABLE_SUMMARY_W)) u_questionable_summary (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .cond_i  (questionable_summary_cond_i),
        .clr_i   (cmd_qevt_q || cmd_cls),
        .latch_o (questionable_summary_latch)
    );

    // No operation condition is ever reported
    edge_event_latch #(.W(OPERATION_SUMMARY_W)) u_operation_summary (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .cond_i  ('0),
        .clr_i   (cmd_oevt_q || cmd_cls),
        .latch_o (operation_summary_latch)
    );

    error_queue #(.DEPTH(EQ_DEPTH)) u_errq (
        .mclk_i        (mclk_i),
        .rst_b_i       (rst_b_i),
        .push_i        (err_push_i),
        .code_i        (err_code_i),
        .pop_i         (cmd_err_q),
        .clear_i       (cmd_cls),
        .head_o        (err_head),
        .not_empty_o   (err_waiting),
        .stored_o      (err_stored),
        .stored_code_o (err_stored_code)
    );

    // ----------------------------------------
    // Local button synchroniser
    // ----------------------------------------
    logic btn_meta_q, btn_sync_q, btn_prev_q;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            btn_meta_q <= 1'b0;
            btn_sync_q <= 1'b0;
            btn_prev_q <= 1'b0;
        end else begin
            btn_meta_q <= local_btn_i;
            btn_sync_q <= btn_meta_q;
            btn_prev_q <= btn_sync_q;
        end
    end

    // ----------------------------------------
    // Masks, event latch, completion arm
    // ----------------------------------------
    logic [7:0]        ese_q, ese_d, sre_q, sre_d, standard_event_latch_q, standard_event_latch_d, standard_event_latch_set;
    logic [QUESTIONABLE_SUMMARY_W-1:0] qen_q, qen_d;
    logic [OPERATION_SUMMARY_W-1:0] oen_q, oen_d;
    opc_state_t        opc_q, opc_d;

    always_comb begin
        ese_d = ese_q;
        sre_d = sre_q;
        qen_d = qen_q;
        oen_d = oen_q;
        opc_d = opc_q;
        if (cmd_valid_i) begin
            case (cmd_code_i)
                CMD_ESE_W: ese_d = cmd_data_i[7:0];
                CMD_SRE_W: sre_d = cmd_data_i[7:0];
                CMD_QEN_W: qen_d = cmd_data_i[QUESTIONABLE_SUMMARY_W-1:0];
                CMD_OEN_W: oen_d = cmd_data_i;
                CMD_PRESET: begin
                    qen_d = '0;
                    oen_d = '0;
                end
                default: ;
            endcase
        end
        standard_event_latch_set = 8'h00;
        case (opc_q)
            OPC_IDLE: begin
                if (cmd_valid_i && cmd_code_i == CMD_OPC) begin
                    opc_d = OPC_ARMED;
                end
            end
            OPC_ARMED: begin
                if (ops_idle_i) begin
                    standard_event_latch_set[EV_ALL_DONE] = 1'b1;
                    opc_d = OPC_IDLE;
                end
            end
            default: opc_d = OPC_IDLE;
        endcase
        if (err_stored) begin
            standard_event_latch_set = standard_event_latch_set | err_class(err_stored_code);
        end
        standard_event_latch_set[EV_LOCAL_BTN] = btn_sync_q && !btn_prev_q;
        // New events win over the read-clear of the same cycle
        standard_event_latch_d = ((cmd_esr_q || cmd_cls) ? 8'h00 : standard_event_latch_q) | standard_event_latch_set;
        standard_event_latch_d = standard_event_latch_d & STANDARD_EVENT_LATCH_LIVE;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ese_q  <= MASK_RST;
            sre_q  <= MASK_RST;
            qen_q  <= '0;
            oen_q  <= '0;
            standard_event_latch_q <= STANDARD_EVENT_LATCH_RST;
            opc_q  <= OPC_IDLE;
        end else begin
            ese_q  <= ese_d;
            sre_q  <= sre_d;
            qen_q  <= qen_d;
            oen_q  <= oen_d;
            standard_event_latch_q <= standard_event_latch_d;
            opc_q  <= opc_d;
        end
    end

    // ----------------------------------------
    // Output queue occupancy
    // ----------------------------------------
    logic [OW-1:0] oq_cnt_q, oq_cnt_d;

    always_comb begin
        oq_cnt_d = msg_start_i ? '0 : oq_cnt_q;
        if (oq_pop_i && oq_cnt_d != '0 && !msg_start_i) begin
            oq_cnt_d = OW'(oq_cnt_d - 1'b1);
        end
        if (oq_push_i && oq_cnt_d != OQ_FULL) begin
            oq_cnt_d = OW'(oq_cnt_d + 1'b1);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            oq_cnt_q <= '0;
        end else begin
            oq_cnt_q <= oq_cnt_d;
        end
    end

    // ----------------------------------------
    // Status summary byte
    // ----------------------------------------
    logic [7:0] sbr_d, sbr_q;

    always_comb begin
        sbr_d          = 8'h00;
        sbr_d[SB_ERR]  = err_waiting;
        sbr_d[SB_QUESTIONABLE_SUMMARY] = |(questionable_summary_latch & qen_q);
        sbr_d[SB_MAV]  = oq_cnt_q != '0;
        sbr_d[SB_ESB]  = |(standard_event_latch_q & ese_q);
        sbr_d[SB_OPERATION_SUMMARY] = |(operation_summary_latch & oen_q);
        sbr_d[SB_RQS]  = |(sbr_d & sre_q & SB_RQS_EXCL);
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sbr_q <= 8'h00;
        end else begin
            sbr_q <= sbr_d;
        end
    end

    assign status_byte_o = sbr_q;
    assign srq_o         = sbr_q[SB_RQS];

    // ----------------------------------------
    // Query answers and serial poll
    // ----------------------------------------
    logic             rsp_valid_q, rsp_valid_d, poll_valid_q;
    logic [RSP_W-1:0] rsp_data_q, rsp_data_d;
    logic [7:0]       poll_data_q;

    always_comb begin
        rsp_valid_d = cmd_valid_i;
        rsp_data_d  = '0;
        case (cmd_code_i)
            CMD_STB_Q:   rsp_data_d = {8'h00, sbr_q};
            CMD_ESR_Q:   rsp_data_d = {8'h00, standard_event_latch_q};
            CMD_ESE_Q:   rsp_data_d = {8'h00, ese_q};
            CMD_SRE_Q:   rsp_data_d = {8'h00, sre_q};
            CMD_QEN_Q:   rsp_data_d = {1'b0, qen_q};
            CMD_QEVT_Q:  rsp_data_d = {1'b0, questionable_summary_latch};
            CMD_QCOND_Q: rsp_data_d = {1'b0, questionable_summary_cond_i};
            CMD_OEN_Q:   rsp_data_d = oen_q;
            CMD_OEVT_Q:  rsp_data_d = operation_summary_latch;
            CMD_ERR_Q:   rsp_data_d = err_head;
            default:     rsp_valid_d = 1'b0;
        endcase
        rsp_valid_d = rsp_valid_d && cmd_valid_i;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_valid_q  <= 1'b0;
            rsp_data_q   <= '0;
            poll_valid_q <= 1'b0;
            poll_data_q  <= 8'h00;
        end else begin
            rsp_valid_q  <= rsp_valid_d;
            rsp_data_q   <= rsp_data_d;
            poll_valid_q <= poll_i;
            poll_data_q  <= sbr_q;
        end
    end

    assign rsp_valid_o  = rsp_valid_q;
    assign rsp_data_o   = rsp_data_q;
    assign poll_valid_o = poll_valid_q;
    assign poll_data_o  = poll_data_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    sequence esr_query_s;
        cmd_esr_q && !cmd_cls;
    endsequence
    sequence esr_answer_s;
        rsp_valid_o && rsp_data_o == {8'h00, $past(standard_event_latch_q)};
    endsequence

    low_bits_zero_a: assert property (status_byte_o[1:0] == 2'b00)
        else $error("summary bits 1:0 not zero");
    err_pending_a: assert property (##1 status_byte_o[SB_ERR] == $past(err_waiting))
        else $error("error bit does not follow queue");
    mav_follow_a: assert property (##1 status_byte_o[SB_MAV] == ($past(oq_cnt_q) != '0))
        else $error("message bit does not follow queue");
    esb_summary_a: assert property (##1 status_byte_o[SB_ESB] == |($past(standard_event_latch_q) & $past(ese_q)))
        else $error("event summary wrong");
    srq_enable_a: assert property (##1 srq_o == |(status_byte_o & $past(sre_q) & SB_RQS_EXCL))
        else $error("service request wrong");
    operation_summary_zero_a: assert property (status_byte_o[SB_OPERATION_SUMMARY] == 1'b0)
        else $error("operation summary not zero");
    esr_read_a: assert property (esr_query_s |=> esr_answer_s and (standard_event_latch_q == $past(standard_event_latch_set & STANDARD_EVENT_LATCH_LIVE)))
        else $error("event query did not answer and clear");
    opc_done_a: assert property (opc_q == OPC_ARMED && ops_idle_i |=> standard_event_latch_q[EV_ALL_DONE] && opc_q == OPC_IDLE)
        else $error("completion bit not set");
    bit1_zero_a: assert property (standard_event_latch_q[1] == 1'b0)
        else $error("event bit 1 set");
    msg_flush_a: assert property (msg_start_i && !oq_push_i |=> oq_cnt_q == '0 ##1 !status_byte_o[SB_MAV])
        else $error("output queue not flushed");
    poll_answer_a: assert property (poll_i |=> poll_valid_o && poll_data_o == $past(sbr_q))
        else $error("poll answer wrong");
    err_class_a: assert property (err_stored && (err_class(err_stored_code) & 8'h20) != 8'h00 |=> standard_event_latch_q[EV_PARSE_ERR])
        else $error("parse error bit not set");
endmodule

// File: tb/host_model.sv
// Bus controller model: commands, serial polls and output queue reads
module host_model
    import status_event_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             rsp_valid_i,
    input  wire logic [RSP_W-1:0] rsp_data_i,
    input  wire logic             poll_valid_i,
    input  wire logic [7:0]       poll_data_i,
    output logic                  cmd_valid_o,
    output cmd_t                  cmd_code_o,
    output logic      [RSP_W-1:0] cmd_data_o,
    output logic                  poll_o,
    output logic                  msg_start_o,
    output logic                  oq_pop_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_code_o  = CMD_STB_Q;
        cmd_data_o  = 16'h0000;
        poll_o      = 1'b0;
        msg_start_o = 1'b0;
        oq_pop_o    = 1'b0;
    end

    // The answer is taken before anything else goes out, so no response is lost
    task automatic send(input cmd_t c, input logic [RSP_W-1:0] d, output logic v, output logic [RSP_W-1:0] r);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o  <= c;
        cmd_data_o  <= d;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_data_o  <= ~d;
        #1;
        v = rsp_valid_i;
        r = rsp_data_i;
    endtask

    task automatic poll(output logic v, output logic [7:0] b);
        @(posedge mclk_i);
        poll_o <= 1'b1;
        @(posedge mclk_i);
        poll_o <= 1'b0;
        #1;
        v = poll_valid_i;
        b = poll_data_i;
    endtask

    // A fresh message drops unread responses; otherwise one response is read
    task automatic read_out(input logic fresh);
        @(posedge mclk_i);
        msg_start_o <= fresh;
        oq_pop_o    <= !fresh;
        @(posedge mclk_i);
        msg_start_o <= 1'b0;
        oq_pop_o    <= 1'b0;
    endtask
endmodule

// File: tb/status_event_reporting_tb.sv
// Self-checking bench for the status and event reporting block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module status_event_reporting_tb;
    import status_event_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EQD = 5;

    logic              mclk_i, rst_b_i, cmd_valid_i, rsp_valid_o, poll_i, poll_valid_o, srq_o;
    logic              msg_start_i, oq_push_i, oq_pop_i, ops_idle_i, err_push_i, local_btn_i;
    cmd_t              cmd_code_i;
    logic [RSP_W-1:0]  cmd_data_i, rsp_data_o;
    logic [CODE_W-1:0] err_code_i;
    logic [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_cond_i;
    logic [7:0]        poll_data_o, status_byte_o;
    int                n_errors, tests_run, cyc, standard_event_latch, ese, sre, qen, oen, qevt, cnt;
    int                eq[$];
    int                codes[4] = '{-100, -222, -313, -420};
    bit                blk;
    logic [31:0]       rng, d;

    status_event_reporting #(.EQ_DEPTH(EQD), .OQ_MAX(4)) status_event_reporting_i (
        .mclk_i, .rst_b_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i, .rsp_valid_o, .rsp_data_o, .poll_i,
        .poll_valid_o, .poll_data_o, .msg_start_i, .oq_push_i, .oq_pop_i, .ops_idle_i, .err_push_i,
        .err_code_i, .questionable_summary_cond_i, .local_btn_i, .status_byte_o, .srq_o
    );

    host_model host_model_i (
        .mclk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o), .poll_valid_i(poll_valid_o),
        .poll_data_i(poll_data_o), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_data_o(cmd_data_i), .poll_o(poll_i), .msg_start_o(msg_start_i), .oq_pop_o(oq_pop_i)
    );

    function automatic int xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic int cls(input int c);
        if (c <= -100 && c > -200) return 32;
        if (c <= -200 && c > -300) return 16;
        if (c <= -300 && c > -400) return 8;
        if (c <= -400 && c > -500) return 4;
        return 0;
    endfunction

    // Operation summary and the two low bits never rise
    function automatic logic [7:0] exp_sb();
        logic [7:0] b;
        b = {2'b00, (standard_event_latch & ese) != 0, cnt != 0, (qevt & qen) != 0, eq.size() != 0, 2'b00};
        b[6] = (b & sre[7:0] & 8'hBF) != 0;
        return b;
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmd(input cmd_t c, input int dat, input logic isq, input int e);
        logic             v;
        logic [RSP_W-1:0] r;
        host_model_i.send(c, dat[15:0], v, r);
        `CHK(v, isq)
        if (isq) `CHK(r, e[15:0])
    endtask

    task automatic mask(input cmd_t w, input cmd_t q, input int dat, input int m, output int val);
        cmd(w, dat, 1'b0, 0);
        val = dat & m;
        cmd(q, 0, 1'b1, val);
    endtask

    // Byte is checked at the pins, by poll and by the status query
    task automatic sb();
        logic       v;
        logic [7:0] p;
        logic [7:0] e;
        repeat (3) @(posedge mclk_i);
        #1;
        e = exp_sb();
        `CHK(status_byte_o, e)
        `CHK(srq_o, e[6])
        host_model_i.poll(v, p);
        `CHK(v, 1'b1)
        `CHK(p, e)
        cmd(CMD_STB_Q, 0, 1'b1, e);
    endtask

    task automatic push(input int c);
        @(posedge mclk_i);
        err_push_i <= 1'b1;
        err_code_i <= c[15:0];
        @(posedge mclk_i);
        err_push_i <= 1'b0;
        if (!blk && eq.size() == EQD - 1) begin
            eq.push_back(-350);
            blk = 1;
            standard_event_latch |= 8;
        end else if (!blk) begin
            eq.push_back(c);
            standard_event_latch |= cls(c);
        end
    endtask

    task automatic esr();
        cmd(CMD_ESR_Q, 0, 1'b1, standard_event_latch);
        standard_event_latch = 0;
    endtask

    task automatic errq();
        if (eq.size() != 0) blk = 0;
        cmd(CMD_ERR_Q, 0, 1'b1, eq.size() != 0 ? eq.pop_front() : 0);
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        rst_b_i = 1'b0;
        oq_push_i = 1'b0;
        ops_idle_i = 1'b1;
        err_push_i = 1'b0;
        err_code_i = '0;
        questionable_summary_cond_i = '0;
        local_btn_i = 1'b0;
        rng = 3711;
        standard_event_latch = 8'h80;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        sb();
        esr();
        esr();
        repeat (3) begin
            mask(CMD_ESE_W, CMD_ESE_Q, xs(), 255, ese);
            mask(CMD_SRE_W, CMD_SRE_Q, xs(), 255, sre);
            mask(CMD_QEN_W, CMD_QEN_Q, xs(), 32'h7FFF, qen);
            mask(CMD_OEN_W, CMD_OEN_Q, xs(), 32'hFFFF, oen);
        end
        cmd(CMD_PRESET, 0, 1'b0, 0);
        cmd(CMD_OEN_Q, 0, 1'b1, 0);
        cmd(CMD_OEVT_Q, 0, 1'b1, 0);
        mask(CMD_ESE_W, CMD_ESE_Q, 255, 255, ese);
        mask(CMD_SRE_W, CMD_SRE_Q, 255, 255, sre);
        mask(CMD_QEN_W, CMD_QEN_Q, 32'hFFFF, 32'h7FFF, qen);
        foreach (codes[i]) push(codes[i]);
        sb();
        esr();
        repeat (5) errq();
        repeat (EQD + 1) push(-310);
        sb();
        repeat (EQD + 1) errq();
        esr();
        ops_idle_i <= 1'b0;
        cmd(CMD_OPC, 0, 1'b0, 0);
        esr();
        ops_idle_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        standard_event_latch |= 1;
        sb();
        esr();
        local_btn_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        standard_event_latch |= 64;
        local_btn_i <= 1'b0;
        esr();
        d = (xs() & 32'h7FFF) | 1;
        questionable_summary_cond_i <= d[14:0];
        qevt = d;
        sb();
        cmd(CMD_QCOND_Q, 0, 1'b1, d);
        cmd(CMD_QEVT_Q, 0, 1'b1, qevt);
        qevt = 0;
        cmd(CMD_QEVT_Q, 0, 1'b1, 0);
        questionable_summary_cond_i <= '0;
        @(posedge mclk_i);
        oq_push_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        oq_push_i <= 1'b0;
        host_model_i.read_out(1'b0);
        cnt = 1;
        sb();
        host_model_i.read_out(1'b1);
        cnt = 0;
        sb();
        push(-100);
        cmd(CMD_CLS, 0, 1'b0, 0);
        standard_event_latch = 0;
        eq.delete();
        blk = 0;
        sb();
        report_and_stop();
    end
endmodule
